/* rtl/board_id_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "board_id_map.svh"
module board_id_regs #(
  parameter logic [3:0] BOARD_REV = `REV_A,
  parameter logic [7:0] BUILD_NUM = 8'h01,
  parameter logic [3:0] TARGET_REV = `REV_A,
  parameter logic SW_READ_OK = 1'b1,
  parameter logic LIGHT_READ_OK = 1'b1,
  parameter logic LOCK_READ_OK = 1'b1,
  parameter logic [7:0] USER_REGS = 8'h08,
  parameter logic [7:0] IMPL_CODE = 8'h5A,   // Arbitrary value
  parameter logic [3:0] VARIANT = 4'h0,
  parameter logic [3:0] ARCH_CODE = 4'h3,    // Arbitrary value
  parameter logic [11:0] NOTE_NUM = 12'h123, // Arbitrary value
  parameter logic [3:0] MINOR_REV = 4'h0
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [11:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [31:0] wdata_i,
  input wire logic [7:0] dll_locked_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Lock inputs come from other clock domains: three stages, vote on last two
  board_id_pkg::dll_vec_t s1_q, s2_q, s3_q, lock_q;
  board_id_pkg::dll_vec_t s1_d, s2_d, s3_d, lock_d;
  board_id_pkg::dll_vec_t mask_q, mask_d;
  board_id_pkg::word_t rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic all_locked;
  board_id_pkg::word_t rev_word, lock_word, build_word, image_word;

  // A bit only changes once two stages agree, filtering one-cycle glitches
  always_comb begin
    s1_d = dll_locked_i;
    s2_d = s1_q;
    s3_d = s2_q;
    lock_d = lock_q;
    for (int i = 0; i < 8; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lock_d[i] = s3_q[i];
      end
    end
  end

  // Reset reports every DLL unlocked until the inputs have settled
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_q <= `LOCK_CLEAR;
      s2_q <= `LOCK_CLEAR;
      s3_q <= `LOCK_CLEAR;
      lock_q <= `LOCK_CLEAR;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lock_q <= lock_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask register: only the top byte of the lock word is writable
  always_comb begin
    mask_d = mask_q;
    if (wr_en_i && addr_i == `OFS_CLOCK_LOCK_STATUS) begin
      mask_d = wdata_i[`LOCK_MASK_LSB +: 8];
    end
  end

  // All DLLs included after reset, so no lock loss is hidden by default
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mask_q <= `LOCK_MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // Excluded DLLs count as locked, so an empty mask reads all-locked
  assign all_locked = &(lock_q | ~mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read words; reserved bits read zero, constants ignore writes
  assign rev_word = {28'h0000000, BOARD_REV};
  assign lock_word = {mask_q, lock_q, 15'h0000, all_locked};
  // Count is clamped so a bad build setting never reports above eight
  assign build_word = {BUILD_NUM, TARGET_REV, 9'h000, SW_READ_OK,
    LIGHT_READ_OK, LOCK_READ_OK,
    (USER_REGS > `USER_REG_MAX) ? `USER_REG_MAX : USER_REGS};
  assign image_word = {IMPL_CODE, VARIANT, ARCH_CODE, NOTE_NUM,
    MINOR_REV};

  // Read mux: one cycle latency, unmapped offsets return zero
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = rd_en_i;
    if (rd_en_i) begin
      unique case (addr_i)
        `OFS_BOARD_REVISION: rdata_d = rev_word;
        `OFS_CLOCK_LOCK_STATUS: rdata_d = lock_word;
        `OFS_BUILD_CAPABILITIES: rdata_d = build_word;
        `OFS_IMAGE_IDENTIFICATION: rdata_d = image_word;
        default: rdata_d = `ZERO_WORD;
      endcase
    end
  end

  // Read port registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_q <= `ZERO_WORD;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Outputs come straight from registers, never from the read mux
  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // All checks sample on the system clock; all but chk_reset_values sleep while reset is held
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Decode of the four mapped offsets, used only by the checks
  logic addr_mapped;
  assign addr_mapped = addr_i == `OFS_BOARD_REVISION ||
    addr_i == `OFS_CLOCK_LOCK_STATUS || addr_i == `OFS_BUILD_CAPABILITIES ||
    addr_i == `OFS_IMAGE_IDENTIFICATION;

  // Register contents seen through the read port
  chk_rev_read: assert property (rd_en_i &&
    addr_i == `OFS_BOARD_REVISION |=> rvalid_o &&
    rdata_o == {28'h0000000, BOARD_REV})
    else $error("board revision read wrong");
  chk_lock_live: assert property (rd_en_i &&
    addr_i == `OFS_CLOCK_LOCK_STATUS |=> rdata_o[23:16] == $past(lock_q))
    else $error("lock bits not live");
  // Independent form of the aggregate: every included DLL is locked
  chk_mask_gate: assert property (
    all_locked == ((lock_q & mask_q) == mask_q))
    else $error("mask gating wrong");
  chk_all_flag: assert property (rd_en_i &&
    addr_i == `OFS_CLOCK_LOCK_STATUS |=> rdata_o[0] ==
    ((rdata_o[23:16] | ~rdata_o[31:24]) == `LOCK_ALL_ONES))
    else $error("aggregate flag wrong");
  // Mask storage: changed only by a write at the lock offset
  chk_mask_write: assert property (wr_en_i &&
    addr_i == `OFS_CLOCK_LOCK_STATUS |=> mask_q == $past(wdata_i[31:24]))
    else $error("mask write lost");
  chk_mask_hold: assert property (!(wr_en_i &&
    addr_i == `OFS_CLOCK_LOCK_STATUS) |=> $stable(mask_q))
    else $error("mask changed without write");
  chk_build_read: assert property (rd_en_i &&
    addr_i == `OFS_BUILD_CAPABILITIES |=> rdata_o[31:20] ==
    {BUILD_NUM, TARGET_REV} && rdata_o[19:11] == 9'h000 &&
    rdata_o[10:8] == {SW_READ_OK, LIGHT_READ_OK, LOCK_READ_OK})
    else $error("build word wrong");
  chk_count_max: assert property (rd_en_i &&
    addr_i == `OFS_BUILD_CAPABILITIES |=> rdata_o[7:0] <= `USER_REG_MAX)
    else $error("user count above eight");
  chk_image_read: assert property (rd_en_i &&
    addr_i == `OFS_IMAGE_IDENTIFICATION |=> rvalid_o && rdata_o ==
    {IMPL_CODE, VARIANT, ARCH_CODE, NOTE_NUM, MINOR_REV})
    else $error("image word wrong");
  chk_unmapped_zero: assert property (rd_en_i && !addr_mapped |=>
    rdata_o == `ZERO_WORD)
    else $error("unmapped read not zero");
  // Read port protocol: valid echoes the strobe, data stands between reads
  chk_rvalid_pulse: assert property (
    rvalid_o == $past(rd_en_i))
    else $error("read valid not one cycle after strobe");
  chk_rdata_hold: assert property (!rd_en_i |=> $stable(rdata_o))
    else $error("read data changed without a read");
  // Filter must hold bit 0 while its stages disagree, follow once all bits of the stages agree
  chk_lock_filter: assert property (s2_q[0] != s3_q[0] |=>
    lock_q[0] == $past(lock_q[0]))
    else $error("lock bit passed disagreement");
  chk_lock_follow: assert property (s2_q == s3_q |=>
    lock_q == $past(s3_q))
    else $error("lock bits ignored agreeing stages");
  // Reset state is checked with the reset itself as the trigger
  chk_reset_values: assert property (disable iff (1'b0) rst_i |=>
    mask_q == `LOCK_MASK_RESET && lock_q == `LOCK_CLEAR &&
    rdata_o == `ZERO_WORD && !rvalid_o)
    else $error("reset values wrong");

  // Main scenarios the bench should reach
  cov_mask_write: cover property (wr_en_i &&
    addr_i == `OFS_CLOCK_LOCK_STATUS);
  cov_all_locked: cover property (!all_locked ##1 all_locked);
  cov_image_read: cover property (rd_en_i &&
    addr_i == `OFS_IMAGE_IDENTIFICATION);
  cov_unmapped: cover property (rd_en_i && !addr_mapped);
  cov_excluded_unlocked: cover property (all_locked &&
    lock_q != `LOCK_ALL_ONES);

endmodule // board_id_regs
`default_nettype wire

/* rtl/board_id_map.svh */
`ifndef BOARD_ID_MAP_SVH
`define BOARD_ID_MAP_SVH
// Register byte offsets
`define OFS_BOARD_REVISION 12'h010
`define OFS_CLOCK_LOCK_STATUS 12'h100
`define OFS_BUILD_CAPABILITIES 12'hFF8
`define OFS_IMAGE_IDENTIFICATION 12'hFFC
// Board revision codes
`define REV_A 4'h0
`define REV_B 4'h1
`define REV_C 4'h2
// Field positions of the lock register
`define LOCK_MASK_LSB 24
`define LOCK_STATE_LSB 16
`define LOCK_ALL_BIT 0
// Field positions of the build register
`define BUILD_NUM_LSB 24
`define BUILD_TARGET_LSB 20
`define BUILD_SW_BIT 10
`define BUILD_LED_BIT 9
`define BUILD_LOCK_BIT 8
// Field positions of the image register
`define IMG_IMPL_LSB 24
`define IMG_VARIANT_LSB 20
`define IMG_ARCH_LSB 16
`define IMG_NOTE_LSB 4
// Reset value of the mask: all DLLs included
`define LOCK_MASK_RESET 8'hFF
// Synchroniser and filtered lock state start unlocked
`define LOCK_CLEAR 8'h00
// Every lock bit set, for comparisons of the whole lock field
`define LOCK_ALL_ONES 8'hFF
`define USER_REG_MAX 8'h08
`define ZERO_WORD 32'h0000_0000
`endif

/* rtl/board_id_pkg.sv */
`default_nettype none
package board_id_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0] dll_vec_t;
endpackage
`default_nettype wire

/* bench/mgmt_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Management controller: single-word reads and writes, strobe one cycle
module mgmt_model (
  input wire logic clk_sys_i,
  output logic [11:0] addr_o,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [31:0] wdata_o,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i
);
  // Idle levels from time zero, so reset is never spent with unknown strobes
  initial begin
    addr_o = 12'h000;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    wdata_o = 32'h0000_0000;
  end
  // Read strobe held to its taking edge; data taken with rvalid
  task automatic read_word(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_en_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_sys_i);
    d = (rvalid_i === 1'b1) ? rdata_i : 32'hDEAD_BEEF;
  endtask
  // Idle address and data flip so stale values cannot pass for good ones
  task automatic write_word(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= d;
    wr_en_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule // mgmt_model
`default_nettype wire

/* bench/board_id_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module board_id_regs_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] dll_locked = 8'h00;
  logic [11:0] addr;
  logic wr_en, rd_en, rvalid;
  logic [31:0] wdata, rdata;
  int num_errors = 0;
  int compares = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  // Five settings moved off their defaults; count set past eight for clamp
  board_id_regs #(.BOARD_REV(4'h2), .LIGHT_READ_OK(1'b0), .USER_REGS(8'h0C),
    .IMPL_CODE(8'h6C), .MINOR_REV(4'h3)) board_id_regs_inst (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .addr_i(addr), .wr_en_i(wr_en), .rd_en_i(rd_en),
    .wdata_i(wdata), .dll_locked_i(dll_locked), .rdata_o(rdata),
    .rvalid_o(rvalid));
  mgmt_model mgmt_model_inst (.clk_sys_i(clk_sys_i), .addr_o(addr),
    .wr_en_o(wr_en), .rd_en_o(rd_en), .wdata_o(wdata), .rdata_i(rdata),
    .rvalid_i(rvalid));
  task automatic end_sim();
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One place compares and reports, so every check counts the same way
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input string what);
    logic [31:0] seen;
    mgmt_model_inst.read_word(a, seen);
    check(seen, exp, what);
  endtask
  // Lock inputs pass a synchroniser and filter, so allow settling edges
  task automatic set_dll(input logic [7:0] v);
    @(posedge clk_sys_i) dll_locked <= v;
    repeat (6) @(posedge clk_sys_i);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd_chk(12'h010, 32'h0000_0002, "revision");
    rd_chk(12'hFF8, 32'h0100_0508, "build");
    rd_chk(12'hFFC, 32'h6C03_1233, "image");
    rd_chk(12'h100, 32'hFF00_0000, "lock at reset");
    set_dll(8'hFF);
    rd_chk(12'h100, 32'hFFFF_0001, "all locked");
    set_dll(8'h7E);
    rd_chk(12'h100, 32'hFF7E_0000, "two unlocked");
    mgmt_model_inst.write_word(12'h100, 32'h7E00_0000);
    rd_chk(12'h100, 32'h7E7E_0001, "masked out");
    // Reserved and status bits written on purpose: nothing may change
    mgmt_model_inst.write_word(12'h100, 32'h7E81_FFFE);
    rd_chk(12'h100, 32'h7E7E_0001, "lock status writes");
    mgmt_model_inst.write_word(12'h010, 32'hFFFF_FFFF);
    rd_chk(12'h010, 32'h0000_0002, "revision writes");
    mgmt_model_inst.write_word(12'hFF8, 32'h0000_0000);
    rd_chk(12'hFF8, 32'h0100_0508, "build writes");
    mgmt_model_inst.write_word(12'hFFC, 32'h0000_0000);
    rd_chk(12'hFFC, 32'h6C03_1233, "image writes");
    mgmt_model_inst.write_word(12'h100, 32'h0000_0000);
    set_dll(8'h00);
    rd_chk(12'h100, 32'h0000_0001, "none included");
    mgmt_model_inst.write_word(12'h100, 32'h0100_0000);
    rd_chk(12'h100, 32'h0100_0000, "one included");
    rd_chk(12'h200, 32'h0000_0000, "unmapped");
    end_sim();
  end
  // Whole run is about ninety cycles; over twenty times that means a hang
  initial begin
    #40000;
    num_errors++;
    end_sim();
  end
endmodule // board_id_regs_bench
`default_nettype wire
